// >>> ddr_ctl_map.vh
/*
 command and timing constants for the power-state tracker.
 assumes a 40 MHz system clock; included by the tracker, the controller model and the testbench.
*/
`ifndef DDR_CTL_MAP_VH
`define DDR_CTL_MAP_VH

// command encodings on {csN, rasN, casN, weN}
`define CMD_MRS        4'h0
`define CMD_REF        4'h1
`define CMD_PRE        4'h2
`define CMD_ACT        4'h3
`define CMD_WR         4'h4
`define CMD_RD         4'h5
`define CMD_NOP        4'h7

`define A10_BIT        10

// timing in ns and derived cycle counts at 25 ns period
`define CLK_NS         25
`define TRFC_NS        128
`define TRFC_CYC       ((`TRFC_NS + `CLK_NS - 1) / `CLK_NS)
`define TXSNR_NS       138
`define TXSNR_CYC      ((`TXSNR_NS + `CLK_NS - 1) / `CLK_NS)
`define TXSRD_CYC      200
`define TWTR_MIN_CYC   2
`define TCKE_CYC       3
`define RD_DONE_CYC    8
`define WR_DONE_CYC    10

`endif

// >>> ddr_cycle_timer.v
/*
 down-counter that reports busy while a loaded interval runs.
 assumes a load pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module ddr_cycle_timer #(
	parameter WIDTH = 8
) (
	input  wire             clk_sys,
	input  wire             rst,
	input  wire             load,
	input  wire [WIDTH-1:0] loadValue,
	output wire             busy
);
	reg [WIDTH-1:0] count_reg;

	always @(posedge clk_sys)
	begin
		if (rst)
			count_reg <= {WIDTH{1'b0}};
		else if (load)
			count_reg <= loadValue;
		else if (count_reg != {WIDTH{1'b0}})
			count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
	end

	assign busy = (count_reg != {WIDTH{1'b0}});
endmodule // ddr_cycle_timer

// >>> ddr_power_state.v
/*
 bank, refresh, self refresh and power-down state tracking of a
 four-bank memory device, plus checks of controller-side obligations.
 assumes command pins and cke arrive from the controller pins
 and pass a three-stage synchroniser to clk_sys.
*/
`timescale 1ns/1ps
`include "ddr_ctl_map.vh"
module ddr_power_state #(
	parameter BANKS = 4
) (
	input  wire       clk_sys,
	input  wire       rst,
	input  wire       ckePin,
	input  wire       csNPin,
	input  wire       rasNPin,
	input  wire       casNPin,
	input  wire       weNPin,
	input  wire       odtPin,
	input  wire [1:0] bankPin,
	input  wire       a10Pin,
	output reg  [3:0] bankOpen,
	output reg        selfRefresh,
	output reg        prechargePowerDown,
	output reg        activePowerDown,
	output reg        refreshBusy,
	output reg        internalRefresh,
	output reg        inputBuffersOn,
	output reg        dllFrozen,
	output reg        readAllowed,
	output reg        protocolError
);
	localparam ST_IDLE = 4'h1;
	localparam ST_SREF = 4'h2;
	localparam ST_PPD  = 4'h4;
	localparam ST_APD  = 4'h8;

	// three-stage synchroniser; decisions use stages two and three only
	reg [2:0] ckeS;
	reg [2:0] csS, rasS, casS, weS, odtS, a10S;
	reg [1:0] bank1, bank2, bank3;
	// integer timing constants cut to the 8-bit counter width on purpose
	localparam [31:0] TRFC_W   = `TRFC_CYC;
	localparam [31:0] TXSNR_W  = `TXSNR_CYC;
	localparam [31:0] TXSRD_W  = `TXSRD_CYC;
	localparam [31:0] TCKE_W   = `TCKE_CYC;
	localparam [31:0] RDDONE_W = `RD_DONE_CYC;
	localparam [31:0] WRDONE_W = `WR_DONE_CYC;
	localparam [31:0] WTROK_W  = `WR_DONE_CYC - `TWTR_MIN_CYC;
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			ckeS <= 3'h7;
			csS <= 3'h7;
			rasS <= 3'h7;
			casS <= 3'h7;
			weS <= 3'h7;
			odtS <= 3'h0;
			a10S <= 3'h0;
			bank1 <= 2'h0;
			bank2 <= 2'h0;
			bank3 <= 2'h0;
		end
		else
		begin
			ckeS <= {ckeS[1:0], ckePin};
			csS <= {csS[1:0], csNPin};
			rasS <= {rasS[1:0], rasNPin};
			casS <= {casS[1:0], casNPin};
			weS <= {weS[1:0], weNPin};
			odtS <= {odtS[1:0], odtPin};
			a10S <= {a10S[1:0], a10Pin};
			bank1 <= bankPin;
			bank2 <= bank1;
			// third stage keeps the bank aligned with the command stage
			bank3 <= bank2;
		end
	end

	// a level counts once stages two and three agree
	reg ckeLvl_reg;
	always @(posedge clk_sys)
	begin
		if (rst)
			ckeLvl_reg <= 1'b1;
		else if (ckeS[1] == ckeS[2])
			ckeLvl_reg <= ckeS[2];
	end

	wire [3:0] cmd = csS[2] ? `CMD_NOP : {1'b0, rasS[2], casS[2], weS[2]};
	wire       isNop = (cmd == `CMD_NOP) || (cmd == 4'h8);
	wire       ckePrev = ckeLvl_reg;
	wire       ckeNow = (ckeS[1] == ckeS[2]) ? ckeS[2] : ckeLvl_reg;
	wire       clockedCmd = ckePrev && ckeNow;

	function [3:0] bankMask;
		input [1:0] b;
		begin
			bankMask = 4'h1 << b;
		end
	endfunction

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [3:0] open_reg;
	reg [3:0] open_next;
	reg [7:0] ckeHold_reg;
	reg [7:0] burst_reg;
	reg [7:0] sinceExit_reg;
	reg       wtr_reg;

	// timers for refresh occupancy and the tXSNR self refresh exit window
	wire refLoad = (state_reg == ST_IDLE) && clockedCmd && (cmd == `CMD_REF);
	wire exitLoad = (state_reg == ST_SREF) && ckeNow;
	wire trfcBusy;
	wire txsnrBusy;
	ddr_cycle_timer #(.WIDTH(8)) refTimer (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.load      (refLoad),
		.loadValue (TRFC_W[7:0]),
		.busy      (trfcBusy)
	);
	ddr_cycle_timer #(.WIDTH(8)) xsnrTimer (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.load      (exitLoad),
		.loadValue (TXSNR_W[7:0]),
		.busy      (txsnrBusy)
	);

	always @*
	begin
		state_next = state_reg;
		open_next = open_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (ckePrev && !ckeNow && cmd == `CMD_REF && open_reg == 4'h0)
					state_next = ST_SREF;
				else if (ckePrev && !ckeNow && isNop && burst_reg == 8'h00)
					state_next = (open_reg == 4'h0) ? ST_PPD : ST_APD;
				else if (clockedCmd)
				begin
					if (cmd == `CMD_ACT)
						open_next = open_reg | bankMask(bank3);
					else if (cmd == `CMD_PRE)
					begin
						if (a10S[2])
							open_next = 4'h0;
						else
							open_next = open_reg & ~bankMask(bank3);
					end
				end
			end
			ST_SREF:
				if (ckeNow)
					state_next = ST_IDLE;
			ST_PPD, ST_APD:
				if (ckeNow && isNop)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	// protocol checks; a set in the same cycle as nothing else, sticky until reset
	wire ckeEdge = (ckeNow != ckePrev);
	wire rwCmd = clockedCmd && (cmd == `CMD_RD || cmd == `CMD_WR);
	wire errRw = rwCmd && !open_reg[bank3];
	wire errRef = refLoad && (open_reg != 4'h0 || trfcBusy);
	wire errSref = (state_reg == ST_IDLE) && ckePrev && !ckeNow && cmd == `CMD_REF
		&& open_reg != 4'h0;
	wire errXsnr = (state_reg == ST_IDLE) && txsnrBusy && clockedCmd && !isNop;
	wire errRead = rwCmd && cmd == `CMD_RD && sinceExit_reg != 8'h00;
	wire errWtr = rwCmd && cmd == `CMD_RD && wtr_reg;
	wire errHold = ckeEdge && ckeHold_reg < TCKE_W[7:0];
	wire errCkeLow = ckePrev && !ckeNow && (burst_reg != 8'h00 || cmd == `CMD_MRS
		|| (sinceExit_reg != 8'h00 && (txsnrBusy || cmd != `CMD_REF)));
	wire errOdt = (state_reg == ST_IDLE && ckePrev && !ckeNow && cmd == `CMD_REF && odtS[2])
		|| (sinceExit_reg != 8'h00 && odtS[2]);
	wire errExit = (state_reg != ST_IDLE) && ckeNow && !isNop;

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			open_reg <= 4'h0;
			ckeHold_reg <= 8'h00;
			burst_reg <= 8'h00;
			sinceExit_reg <= 8'h00;
			wtr_reg <= 1'b0;
			bankOpen <= 4'h0;
			selfRefresh <= 1'b0;
			prechargePowerDown <= 1'b0;
			activePowerDown <= 1'b0;
			refreshBusy <= 1'b0;
			internalRefresh <= 1'b0;
			inputBuffersOn <= 1'b1;
			dllFrozen <= 1'b0;
			readAllowed <= 1'b1;
			protocolError <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			open_reg <= open_next;
			if (ckeEdge)
				ckeHold_reg <= 8'h01;
			else if (ckeHold_reg != 8'hFF)
				ckeHold_reg <= ckeHold_reg + 8'h01;
			// burst occupancy; write adds tWR, tWTR at least two clocks
			if (rwCmd)
				burst_reg <= (cmd == `CMD_RD) ? RDDONE_W[7:0] : WRDONE_W[7:0];
			else if (burst_reg != 8'h00)
				burst_reg <= burst_reg - 8'h01;
			if (rwCmd)
				wtr_reg <= (cmd == `CMD_WR);
			else if (burst_reg <= WTROK_W[7:0])
				wtr_reg <= 1'b0;
			if (exitLoad)
				sinceExit_reg <= TXSRD_W[7:0];
			else if (sinceExit_reg != 8'h00)
				sinceExit_reg <= sinceExit_reg - 8'h01;
			bankOpen <= open_next;
			selfRefresh <= (state_next == ST_SREF);
			prechargePowerDown <= (state_next == ST_PPD);
			activePowerDown <= (state_next == ST_APD);
			refreshBusy <= refLoad || trfcBusy;
			// only self refresh refreshes; power-down never does
			internalRefresh <= (state_next == ST_SREF);
			inputBuffersOn <= (state_next == ST_IDLE);
			dllFrozen <= (state_next == ST_PPD);
			readAllowed <= !(exitLoad || sinceExit_reg > 8'h01);
			if (errRw || errRef || errSref || errXsnr || errRead || errWtr || errHold
				|| errCkeLow || errOdt || errExit)
				protocolError <= 1'b1;
		end
	end
endmodule // ddr_power_state

// >>> ddr_power_state_assertions.sv
/*
 checker for the power-state tracker outputs.
 assumes bind onto ddr_power_state, single clock domain.
*/
`timescale 1ns/1ps
module ddr_power_state_checker (
	input wire       clk_sys,
	input wire       rst,
	input wire [3:0] bankOpen,
	input wire       selfRefresh,
	input wire       prechargePowerDown,
	input wire       activePowerDown,
	input wire       refreshBusy,
	input wire       internalRefresh,
	input wire       inputBuffersOn,
	input wire       dllFrozen,
	input wire       readAllowed,
	input wire       protocolError
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire lowPower = selfRefresh | prechargePowerDown | activePowerDown;
	sequence refreshRun;
		refreshBusy[*5] ##[1:3] !refreshBusy;
	endsequence
	sequence readHold;
		##[0:2] !readAllowed[*8];
	endsequence
	state_onehot_a: assert property ($onehot0({selfRefresh, prechargePowerDown, activePowerDown}))
		else $error("two low-power states at once");
	buffers_off_a: assert property (inputBuffersOn == !lowPower)
		else $error("input buffers wrong for state");
	dll_frozen_a: assert property (dllFrozen == prechargePowerDown)
		else $error("dll freeze wrong for state");
	self_refresh_a: assert property (internalRefresh == selfRefresh)
		else $error("internal refresh outside self refresh");
	ppd_idle_a: assert property ($rose(prechargePowerDown) |-> bankOpen == 4'h0)
		else $error("precharge power-down with open bank");
	apd_open_a: assert property ($rose(activePowerDown) |-> bankOpen != 4'h0)
		else $error("active power-down with banks idle");
	sr_idle_a: assert property ($rose(selfRefresh) |-> bankOpen == 4'h0)
		else $error("self refresh with open bank");
	refresh_len_a: assert property ($rose(refreshBusy) |-> refreshRun)
		else $error("refresh busy length wrong");
	read_block_a: assert property ($fell(selfRefresh) |-> readHold)
		else $error("read allowed too soon after exit");
	error_sticky_a: assert property (protocolError |=> protocolError)
		else $error("error flag dropped");
endmodule // ddr_power_state_checker
bind ddr_power_state ddr_power_state_checker chk (.clk_sys(clk_sys), .rst(rst),
	.bankOpen(bankOpen), .selfRefresh(selfRefresh), .prechargePowerDown(prechargePowerDown),
	.activePowerDown(activePowerDown), .refreshBusy(refreshBusy),
	.internalRefresh(internalRefresh), .inputBuffersOn(inputBuffersOn),
	.dllFrozen(dllFrozen), .readAllowed(readAllowed), .protocolError(protocolError));

// >>> ddr_ctl_model.sv
/*
 memory controller model driving command pins and cke.
 assumes issue is called just after a falling edge.
*/
`timescale 1ns/1ps
`include "ddr_ctl_map.vh"
module ddr_ctl_model (
	input wire       clk_sys,
	output reg       ckePin,
	output reg [3:0] cmdPins,
	output reg [1:0] bankPin,
	output reg       a10Pin
);
	initial
	begin
		ckePin = 1'b1;
		cmdPins = `CMD_NOP;
		bankPin = 2'h0;
		a10Pin = 1'b0;
	end
	// one-cycle command, cke level stays; caller spaces cke changes >= 3 edges
	task issue(input [3:0] c, input [1:0] b, input a, input k);
		cmdPins = c;
		bankPin = b;
		a10Pin = a;
		ckePin = k;
		@(negedge clk_sys);
		cmdPins = `CMD_NOP;
		bankPin = ~b;
		a10Pin = ~a;
	endtask
endmodule // ddr_ctl_model

// >>> testbench.sv
/*
 self-checking bench for the power-state tracker.
 assumes the controller model drives all pins except odt, which the bench ties low.
*/
`timescale 1ns/1ps
`include "ddr_ctl_map.vh"
module testbench;
	reg        clk_sys;
	reg        rst;
	integer    errors;
	integer    num_checks;
	wire       ckePin;
	wire [3:0] cmdPins;
	wire [1:0] bankPin;
	wire       a10Pin;
	wire [3:0] bankOpen;
	wire       sr, ppd, apd, rb, ir, ibo, dll, ra, pe;
	ddr_ctl_model ctl (.clk_sys(clk_sys), .ckePin(ckePin), .cmdPins(cmdPins),
		.bankPin(bankPin), .a10Pin(a10Pin));
	ddr_power_state DUT (.clk_sys(clk_sys), .rst(rst), .ckePin(ckePin),
		.csNPin(cmdPins[3]), .rasNPin(cmdPins[2]), .casNPin(cmdPins[1]),
		.weNPin(cmdPins[0]), .odtPin(1'b0), .bankPin(bankPin), .a10Pin(a10Pin),
		.bankOpen(bankOpen), .selfRefresh(sr), .prechargePowerDown(ppd),
		.activePowerDown(apd), .refreshBusy(rb), .internalRefresh(ir),
		.inputBuffersOn(ibo), .dllFrozen(dll), .readAllowed(ra), .protocolError(pe));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task check(input string what, input [3:0] seen, input [3:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			errors = errors + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// six cycles covers the three-stage synchroniser plus output register
	task cmd(input [3:0] c, input [1:0] b, input a, input k);
		ctl.issue(c, b, a, k);
		repeat (5) @(negedge clk_sys);
	endtask
	task summarize;
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task test_banks;
		check("reset", {ibo, ra, pe, sr}, 4'hC);
		check("bankOpen", bankOpen, 4'h0);
		cmd(`CMD_ACT, 2'h1, 1'b0, 1'b1);
		cmd(`CMD_ACT, 2'h2, 1'b0, 1'b1);
		check("bankOpen", bankOpen, 4'h6);
		cmd(`CMD_PRE, 2'h1, 1'b0, 1'b1);
		check("bankOpen", bankOpen, 4'h4);
		cmd(`CMD_ACT, 2'h3, 1'b0, 1'b1);
		cmd(`CMD_PRE, 2'h1, 1'b1, 1'b1);
		check("bankOpen", bankOpen, 4'h0);
	endtask
	task test_refresh;
		ctl.issue(`CMD_REF, 2'h0, 1'b0, 1'b1);
		repeat (4) @(negedge clk_sys);
		check("refreshBusy", rb, 4'h1);
		repeat (10) @(negedge clk_sys);
		check("refreshBusy", rb, 4'h0);
	endtask
	task test_powerdown;
		cmd(`CMD_NOP, 2'h0, 1'b0, 1'b0);
		check("ppd", {ppd, apd, dll, ibo}, 4'hA);
		check("internalRefresh", ir, 4'h0);
		cmd(`CMD_NOP, 2'h0, 1'b0, 1'b1);
		check("ppd exit", {ppd, apd, dll, ibo}, 4'h1);
		cmd(`CMD_ACT, 2'h0, 1'b0, 1'b1);
		cmd(`CMD_NOP, 2'h0, 1'b0, 1'b0);
		check("apd", {ppd, apd, dll, ibo}, 4'h4);
		cmd(`CMD_NOP, 2'h0, 1'b0, 1'b1);
		check("apd exit", {ppd, apd, bankOpen[0], ibo}, 4'h3);
		cmd(`CMD_PRE, 2'h0, 1'b1, 1'b1);
	endtask
	task test_selfref;
		cmd(`CMD_REF, 2'h0, 1'b0, 1'b0);
		check("self refresh", {sr, ir, ibo, ppd}, 4'hC);
		ctl.issue(`CMD_NOP, 2'h0, 1'b0, 1'b1);
		repeat (100) @(negedge clk_sys);
		check("readAllowed", {sr, ra}, 4'h0);
		repeat (110) @(negedge clk_sys);
		check("readAllowed", {sr, ra, pe}, 4'h2);
		cmd(`CMD_REF, 2'h0, 1'b0, 1'b0);
		ctl.issue(`CMD_NOP, 2'h0, 1'b0, 1'b1);
		repeat (12) @(negedge clk_sys);
		cmd(`CMD_RD, 2'h0, 1'b0, 1'b1);
		check("protocolError", pe, 4'h1);
	endtask
	initial
	begin
		errors = 0;
		num_checks = 0;
		rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		test_banks;
		test_refresh;
		test_powerdown;
		test_selfref;
		summarize;
	end
	initial
	begin
		#100000;
		errors = errors + 1;
		summarize;
	end
endmodule // testbench
